// >>> kmac_pkg.sv
// Constants, types and register map of the keypad menu and alarm block
package kmac_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned IDLE_TIMEOUT_S = 10;
  localparam int unsigned FRESET_HOLD_S = 3;
  localparam int unsigned BANNER_MS = 2000;
  localparam int unsigned IDLE_CYC = IDLE_TIMEOUT_S * CLK_HZ;
  localparam int unsigned FRESET_CYC = FRESET_HOLD_S * CLK_HZ;
  localparam int unsigned BANNER_CYC = BANNER_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 28;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_OUTCFG = 8'h08;
  localparam logic [7:0] REG_AVG = 8'h0c;
  localparam logic [7:0] REG_PEAK = 8'h10;
  localparam logic [7:0] REG_VALLEY = 8'h14;
  localparam logic [7:0] REG_ALARM = 8'h18;
  localparam logic [7:0] REG_OLIM = 8'h1c;
  localparam logic [7:0] REG_RANGE = 8'h20;
  localparam logic [7:0] REG_AMB = 8'h24;

  // Control register fields
  localparam int unsigned CTRL_W = 10;
  localparam int unsigned CTRL_CH1_DIG = 0;
  localparam int unsigned CTRL_CH2_DIG = 1;
  localparam int unsigned CTRL_AL1_HIGH = 2;
  localparam int unsigned CTRL_AL2_HIGH = 3;
  localparam int unsigned CTRL_AL1_NC = 4;
  localparam int unsigned CTRL_AL2_NC = 5;
  localparam int unsigned CTRL_AL1_SRC = 6;
  localparam int unsigned CTRL_AL2_SRC = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h018;
  localparam logic [1:0] SRC_OBJ = 2'h0;
  localparam logic [1:0] SRC_HEAD = 2'h1;
  localparam logic [1:0] SRC_BOX = 2'h2;

  // Value limits and steps (temperatures in 0.1 C, outputs in mV or uA)
  localparam logic signed [15:0] TIME_MAX = 16'sh270f;
  localparam logic signed [15:0] HOLD_INF = 16'sh2710;
  localparam logic signed [15:0] TEMP_MIN = 16'shfe70;
  localparam logic signed [15:0] TEMP_MAX = 16'sh2328;
  localparam logic signed [15:0] HYST = 16'sh0014;
  localparam logic signed [15:0] STEP_FINE = 16'sh0001;
  localparam logic signed [15:0] STEP_OUT = 16'sh000a;
  localparam logic signed [15:0] SPAN_MA = 16'sh4e20;
  localparam logic signed [15:0] SPAN_MA_LO4 = 16'sh0fa0;
  localparam logic signed [15:0] SPAN_V5 = 16'sh1388;
  localparam logic signed [15:0] SPAN_V10 = 16'sh2710;
  localparam logic signed [15:0] ZERO = 16'sh0000;

  typedef enum logic [3:0] {
    DM_INIT = 4'b0001,
    DM_TEMP = 4'b0010,
    DM_MENU = 4'b0100,
    DM_RESET = 4'b1000
  } kmac_disp_e;

  typedef enum logic [3:0] {
    F_OUT = 4'h0, F_AVG = 4'h1, F_PEAK = 4'h2, F_VALLEY = 4'h3,
    F_RLO = 4'h4, F_RHI = 4'h5, F_OLO = 4'h6, F_OHI = 4'h7,
    F_UNIT = 4'h8, F_ALO = 4'h9, F_AHI = 4'ha, F_AMB = 4'hb
  } kmac_func_e;

  typedef enum logic [2:0] {
    MA_0_20 = 3'h0, MA_4_20 = 3'h1, VOLT_OUT_5 = 3'h2,
    VOLT_OUT_10 = 3'h3, THERMOCOUPLE_J_OUT = 3'h4,
    THERMOCOUPLE_K_OUT = 3'h5
  } kmac_otype_e;

  localparam logic [2:0] BL_RED = 3'h4;
  localparam logic [2:0] BL_GREEN = 3'h2;
  localparam logic [2:0] BL_BLUE = 3'h1;

  typedef struct packed {
    logic sel;
    logic up;
    logic dn;
  } kmac_keys_s;

  typedef struct packed {
    logic signed [15:0] object_temperature;
    logic signed [15:0] sensor_head_temperature;
    logic signed [15:0] controller_box_temperature;
  } kmac_temps_s;

  typedef struct packed {
    kmac_otype_e out_type;
    logic fahrenheit;
    logic range_en;
    logic [13:0] avg_time;
    logic [13:0] peak_time;
    logic [13:0] valley_time;
    logic signed [15:0] range_lo;
    logic signed [15:0] range_hi;
    logic signed [15:0] olim_lo;
    logic signed [15:0] olim_hi;
    logic signed [15:0] alarm_lo;
    logic signed [15:0] alarm_hi;
    logic amb_fixed;
    logic signed [15:0] amb_value;
  } kmac_cfg_s;

  localparam kmac_cfg_s CFG_DEFAULT = '{
    out_type: VOLT_OUT_5, fahrenheit: 1'b0, range_en: 1'b1,
    avg_time: 14'h0002, peak_time: 14'h0000, valley_time: 14'h0000,
    range_lo: 16'sh0000, range_hi: 16'sh1388,
    olim_lo: 16'sh0000, olim_hi: 16'sh1388,
    alarm_lo: 16'sh012c, alarm_hi: 16'sh03e8,
    amb_fixed: 1'b0, amb_value: 16'sh00fa
  };

endpackage : kmac_pkg

// >>> kmac_top.sv
// Keypad menu, factory reset, alarm comparators and APB registers
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module kmac_top import kmac_pkg::*; #(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned FRESET_CYCLES = FRESET_CYC,
  parameter int unsigned BANNER_CYCLES = BANNER_CYC
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Keys and temperatures
  input wire kmac_keys_s keys,
  input wire kmac_temps_s temps,
  // Display and settings
  output kmac_disp_e disp_mode,
  output kmac_func_e disp_func,
  output logic signed [15:0] disp_value,
  output kmac_cfg_s cfg,
  // Alarm outputs
  output logic [2:0] backlight,
  output logic ch1_alarm,
  output logic ch2_alarm,
  output logic open_collector_alarm_pin_o,
  output logic open_collector_alarm_pin_oe_n
);

  kmac_keys_s key_q;
  kmac_disp_e disp_q;
  kmac_func_e func_q;
  kmac_cfg_s cfg_q;
  kmac_otype_e type_nx;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] hold_q;
  logic combo_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [1:0] al_q;
  logic [2:0] bl_q;
  logic ch1_q, ch2_q, oc_oe_n_q, oc_o_q;
  logic signed [15:0] dval_q;
  logic [31:0] prdata_q, rd_data;
  logic pready_q, pslverr_q, hit;
  logic sel_rise, up_rise, dn_rise, any_rise;
  logic up_step, dn_step, sel_step, both_rise, freset, edit;
  logic signed [15:0] al1_t, al2_t;

  // Clamped step of a value by one increment up or down
  function automatic logic signed [15:0] step_val(
    input logic signed [15:0] v, input logic up,
    input logic signed [15:0] stp, input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    logic signed [16:0] n;
    n = up ? 17'(v) + 17'(stp) : 17'(v) - 17'(stp);
    if (n > 17'(hi)) n = 17'(hi);
    if (n < 17'(lo)) n = 17'(lo);
    return n[15:0];
  endfunction : step_val

  function automatic logic signed [15:0] span_lo(input kmac_otype_e t);
    return (t == MA_4_20) ? SPAN_MA_LO4 : ZERO;
  endfunction : span_lo

  function automatic logic signed [15:0] span_hi(input kmac_otype_e t);
    logic signed [15:0] r;
    case (t)
      MA_0_20, MA_4_20: r = SPAN_MA;
      VOLT_OUT_5: r = SPAN_V5;
      VOLT_OUT_10: r = SPAN_V10;
      default: r = ZERO;
    endcase
    return r;
  endfunction : span_hi

  function automatic logic is_tc(input kmac_otype_e t);
    return (t == THERMOCOUPLE_J_OUT) || (t == THERMOCOUPLE_K_OUT);
  endfunction : is_tc

  function automatic logic signed [15:0] pick(input logic [1:0] s);
    logic signed [15:0] r;
    case (s)
      SRC_HEAD: r = temps.sensor_head_temperature;
      SRC_BOX: r = temps.controller_box_temperature;
      default: r = temps.object_temperature;
    endcase
    return r;
  endfunction : pick

  // Hysteresis comparator: sets past threshold, clears 2 K back inside
  function automatic logic alarm_nx(input logic st,
    input logic signed [15:0] t, input logic signed [15:0] thr,
    input logic high);
    logic signed [16:0] tt, th;
    tt = 17'(t);
    th = 17'(thr);
    if (high ? (tt > th) : (tt < th)) return 1'b1;
    if (high ? (tt < th - 17'(HYST)) : (tt > th + 17'(HYST)))
      return 1'b0;
    return st;
  endfunction : alarm_nx

  // Key edges; inputs arrive synchronous so one stage suffices
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      key_q <= '0;
    end else if (ce) begin
      key_q <= keys;
    end
  end

  assign sel_rise = keys.sel & ~key_q.sel;
  assign up_rise = keys.up & ~key_q.up;
  assign dn_rise = keys.dn & ~key_q.dn;
  assign any_rise = sel_rise | up_rise | dn_rise;
  // A single key steps only while its partner is released
  assign up_step = up_rise & ~keys.dn;
  assign dn_step = dn_rise & ~keys.up;
  assign both_rise = keys.up & keys.dn & (up_rise | dn_rise);
  // Select with down held belongs to the factory reset gesture
  assign sel_step = sel_rise & ~keys.dn;
  assign edit = (disp_q == DM_MENU) & ~freset;

  // Factory reset gesture: down first, then select, both held
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      combo_q <= 1'b0;
      hold_q <= '0;
    end else if (ce) begin
      if (!(keys.dn && keys.sel)) begin
        combo_q <= 1'b0;
        hold_q <= '0;
      end else if (sel_rise && key_q.dn) begin
        combo_q <= 1'b1;
        hold_q <= '0;
      end else if (combo_q && hold_q != CNT_W'(FRESET_CYCLES)) begin
        hold_q <= hold_q + 1'b1;
      end
    end
  end

  // One pulse per gesture; the counter parks at the end value
  assign freset = combo_q && (hold_q == CNT_W'(FRESET_CYCLES - 1));

  // Display mode, function pointer and banner/idle timer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      disp_q <= DM_INIT;
      func_q <= F_OUT;
      cnt_q <= '0;
    end else if (ce) begin
      if (freset) begin
        disp_q <= DM_RESET;
        cnt_q <= '0;
      end else begin
        case (disp_q)
          DM_INIT, DM_RESET: begin
            if (cnt_q >= CNT_W'(BANNER_CYCLES - 1)) begin
              disp_q <= DM_TEMP;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          DM_TEMP: begin
            if (sel_step) begin
              disp_q <= DM_MENU; // Pointer kept
              cnt_q <= '0;
            end
          end
          DM_MENU: begin
            if (any_rise) begin
              cnt_q <= '0;
              if (sel_step) begin
                func_q <= (func_q == F_AMB) ? F_OUT
                        : kmac_func_e'(func_q + 4'h1);
              end
            end else if (cnt_q == CNT_W'(IDLE_CYCLES)) begin
              disp_q <= DM_TEMP;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          default: disp_q <= DM_TEMP;
        endcase
      end
    end
  end

  // Next output type, saturating at both ends of the list
  always_comb begin
    type_nx = cfg_q.out_type;
    if (up_step && cfg_q.out_type != THERMOCOUPLE_K_OUT)
      type_nx = kmac_otype_e'(cfg_q.out_type + 3'h1);
    else if (dn_step && cfg_q.out_type != MA_0_20)
      type_nx = kmac_otype_e'(cfg_q.out_type - 3'h1);
  end

  // Parameter edits take effect on the key edge itself, no confirm step
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CFG_DEFAULT;
    end else if (ce) begin
      if (freset) begin
        cfg_q <= CFG_DEFAULT;
      end else if (edit && func_q == F_AMB && both_rise) begin
        cfg_q.amb_fixed <= 1'b0;
      end else if (edit && (up_step || dn_step)) begin
        case (func_q)
          F_OUT: begin
            cfg_q.out_type <= type_nx;
            cfg_q.range_en <= ~is_tc(type_nx);
            // Limits snap to the new span so they never fall outside it
            cfg_q.olim_lo <= span_lo(type_nx);
            cfg_q.olim_hi <= span_hi(type_nx);
          end
          F_AVG: cfg_q.avg_time <= 14'(step_val(16'(cfg_q.avg_time),
                   up_step, STEP_FINE, ZERO, TIME_MAX));
          F_PEAK: begin
            cfg_q.peak_time <= 14'(step_val(16'(cfg_q.peak_time),
              up_step, STEP_FINE, ZERO, HOLD_INF));
            cfg_q.valley_time <= '0;
          end
          F_VALLEY: begin
            cfg_q.valley_time <= 14'(step_val(16'(cfg_q.valley_time),
              up_step, STEP_FINE, ZERO, HOLD_INF));
            cfg_q.peak_time <= '0;
          end
          F_RLO: if (cfg_q.range_en) cfg_q.range_lo <= step_val(
                   cfg_q.range_lo, up_step, STEP_FINE, TEMP_MIN,
                   cfg_q.range_hi);
          F_RHI: if (cfg_q.range_en) cfg_q.range_hi <= step_val(
                   cfg_q.range_hi, up_step, STEP_FINE, cfg_q.range_lo,
                   TEMP_MAX);
          F_OLO: cfg_q.olim_lo <= step_val(cfg_q.olim_lo, up_step,
                   STEP_OUT, span_lo(cfg_q.out_type), cfg_q.olim_hi);
          F_OHI: cfg_q.olim_hi <= step_val(cfg_q.olim_hi, up_step,
                   STEP_OUT, cfg_q.olim_lo, span_hi(cfg_q.out_type));
          F_UNIT: cfg_q.fahrenheit <= ~cfg_q.fahrenheit;
          F_ALO: cfg_q.alarm_lo <= step_val(cfg_q.alarm_lo, up_step,
                   STEP_FINE, TEMP_MIN, TEMP_MAX);
          F_AHI: cfg_q.alarm_hi <= step_val(cfg_q.alarm_hi, up_step,
                   STEP_FINE, TEMP_MIN, TEMP_MAX);
          F_AMB: begin
            // First press leaves head mode and keeps the stored value
            if (!cfg_q.amb_fixed) cfg_q.amb_fixed <= 1'b1;
            else cfg_q.amb_value <= step_val(cfg_q.amb_value, up_step,
                   STEP_FINE, TEMP_MIN, TEMP_MAX);
          end
          default: cfg_q <= cfg_q;
        endcase
      end
    end
  end

  // Value shown beside the mode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dval_q <= ZERO;
    end else if (ce) begin
      if (disp_q == DM_TEMP) begin
        dval_q <= temps.object_temperature;
      end else if (disp_q != DM_MENU) begin
        dval_q <= ZERO;
      end else begin
        case (func_q)
          F_OUT: dval_q <= 16'(cfg_q.out_type);
          F_AVG: dval_q <= 16'(cfg_q.avg_time);
          F_PEAK: dval_q <= 16'(cfg_q.peak_time);
          F_VALLEY: dval_q <= 16'(cfg_q.valley_time);
          F_RLO: dval_q <= cfg_q.range_lo;
          F_RHI: dval_q <= cfg_q.range_hi;
          F_OLO: dval_q <= cfg_q.olim_lo;
          F_OHI: dval_q <= cfg_q.olim_hi;
          F_UNIT: dval_q <= 16'(cfg_q.fahrenheit);
          F_ALO: dval_q <= cfg_q.alarm_lo;
          F_AHI: dval_q <= cfg_q.alarm_hi;
          default: dval_q <= cfg_q.amb_value;
        endcase
      end
    end
  end

  // Alarm comparators; sources and directions come from the host only
  assign al1_t = pick(ctrl_q[CTRL_AL1_SRC +: 2]);
  assign al2_t = pick(ctrl_q[CTRL_AL2_SRC +: 2]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      al_q <= 2'h0;
    end else if (ce) begin
      al_q[0] <= alarm_nx(al_q[0], al1_t, cfg_q.alarm_lo,
                          ctrl_q[CTRL_AL1_HIGH]);
      al_q[1] <= alarm_nx(al_q[1], al2_t, cfg_q.alarm_hi,
                          ctrl_q[CTRL_AL2_HIGH]);
    end
  end

  // Alarm drivers; contact level follows normally-open/closed choice
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bl_q <= BL_GREEN;
      ch1_q <= 1'b0;
      ch2_q <= 1'b0;
      oc_oe_n_q <= 1'b1;
      oc_o_q <= 1'b0;
    end else if (ce) begin
      bl_q <= al_q[1] ? BL_RED : al_q[0] ? BL_BLUE : BL_GREEN;
      ch1_q <= ctrl_q[CTRL_CH1_DIG]
               & (al_q[0] ^ ctrl_q[CTRL_AL1_NC]);
      ch2_q <= ctrl_q[CTRL_CH2_DIG]
               & (al_q[1] ^ ctrl_q[CTRL_AL2_NC]);
      // Open collector only sinks; released means no drive
      oc_oe_n_q <= ~(al_q[1] ^ ctrl_q[CTRL_AL2_NC]);
      oc_o_q <= 1'b0;
    end
  end

  // Register read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == REG_CTRL) begin
      rd_data = 32'(ctrl_q);
    end else if (paddr == REG_STATUS) begin
      rd_data = {20'h00000, func_q, 3'h0, disp_q == DM_RESET,
                 disp_q == DM_MENU, disp_q == DM_INIT, al_q};
    end else if (paddr == REG_OUTCFG) begin
      rd_data = {26'h0000000, cfg_q.amb_fixed, cfg_q.range_en,
                 cfg_q.fahrenheit, cfg_q.out_type};
    end else if (paddr == REG_AVG) begin
      rd_data = 32'(cfg_q.avg_time);
    end else if (paddr == REG_PEAK) begin
      rd_data = 32'(cfg_q.peak_time);
    end else if (paddr == REG_VALLEY) begin
      rd_data = 32'(cfg_q.valley_time);
    end else if (paddr == REG_ALARM) begin
      rd_data = {cfg_q.alarm_hi, cfg_q.alarm_lo};
    end else if (paddr == REG_OLIM) begin
      rd_data = {cfg_q.olim_hi, cfg_q.olim_lo};
    end else if (paddr == REG_RANGE) begin
      rd_data = {cfg_q.range_hi, cfg_q.range_lo};
    end else if (paddr == REG_AMB) begin
      rd_data = {16'h0000, cfg_q.amb_value};
    end else begin
      hit = 1'b0;
    end
  end

  // APB handshake: one wait state, answer registered for clean timing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

  // Host-only alarm configuration; keys never reach it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
    end else if (ce) begin
      if (psel && penable && pready_q && pwrite && paddr == REG_CTRL) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign disp_mode = disp_q;
  assign disp_func = func_q;
  assign disp_value = dval_q;
  assign cfg = cfg_q;
  assign backlight = bl_q;
  assign ch1_alarm = ch1_q;
  assign ch2_alarm = ch2_q;
  assign open_collector_alarm_pin_o = oc_o_q;
  assign open_collector_alarm_pin_oe_n = oc_oe_n_q;

endmodule : kmac_top

`default_nettype wire

// >>> kmac_keys_model.sv
// Push-button model: key levels follow the requested pattern
`timescale 1ns/1ps
`default_nettype none
module kmac_keys_model import kmac_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Request and key levels
  input wire kmac_keys_s want,
  output kmac_keys_s keys
);
  // Keys held whole cycles, so a gesture keeps both keys down
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) keys <= '0;
    else keys <= want;
  end
endmodule : kmac_keys_model
`default_nettype wire

// >>> kmac_checker.sv
// Port assertions for the keypad menu and alarm block
`timescale 1ns/1ps
`default_nettype none
module kmac_checker import kmac_pkg::*; #(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned FRESET_CYCLES = FRESET_CYC,
  parameter int unsigned BANNER_CYCLES = BANNER_CYC
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Keys, temperatures and outputs
  input wire kmac_keys_s keys,
  input wire kmac_temps_s temps,
  input wire kmac_disp_e disp_mode,
  input wire kmac_func_e disp_func,
  input wire kmac_cfg_s cfg,
  input wire logic [2:0] backlight
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  kmac_keys_s keys_q;
  int unsigned idle_q;
  int unsigned show_q;
  logic rise;
  assign rise = |(keys & ~keys_q);
  // Idle and banner spans; counters avoid long repetitions
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      keys_q <= '0;
      idle_q <= 0;
      show_q <= 0;
    end else begin
      keys_q <= keys;
      idle_q <= (disp_mode != DM_MENU || rise) ? 0 : idle_q + 1;
      show_q <= (disp_mode inside {DM_INIT, DM_RESET}) ? show_q + 1 : 0;
    end
  end
  AST_PREADY: assert property (psel && penable && !pready && ce |=> pready)
    else $error("no answer after access edge");
  AST_MENU: assert property (disp_mode == DM_MENU && keys.sel && !keys_q.sel
    && !keys.dn && !keys_q.dn |-> ##[1:2] $changed(disp_func))
    else $error("select did not advance");
  AST_IDLE: assert property (idle_q <= IDLE_CYCLES + 3)
    else $error("menu outlived idle span");
  AST_SHOW: assert property (show_q <= BANNER_CYCLES + 2)
    else $error("banner too long");
  AST_PV: assert property (cfg.peak_time == '0 || cfg.valley_time == '0)
    else $error("peak and valley both on");
  AST_TC: assert property (cfg.out_type inside {THERMOCOUPLE_J_OUT,
    THERMOCOUPLE_K_OUT} |-> !cfg.range_en)
    else $error("range on for thermocouple");
  AST_RED: assert property ((temps.object_temperature > cfg.alarm_hi + HYST)
    [*3] |=> backlight == BL_RED)
    else $error("high alarm not red");
  AST_GREEN: assert property ((temps.object_temperature > cfg.alarm_lo + HYST
    && temps.object_temperature < cfg.alarm_hi - HYST)[*3]
    |=> backlight == BL_GREEN)
    else $error("no alarm not green");
endmodule : kmac_checker
bind kmac_top kmac_checker #(.IDLE_CYCLES(IDLE_CYCLES),
  .FRESET_CYCLES(FRESET_CYCLES), .BANNER_CYCLES(BANNER_CYCLES))
  i_kmac_checker (.*);
`default_nettype wire

// >>> kmac_top_bench.sv
// Self-checking bench for the keypad menu and alarm block
`timescale 1ns/1ps
`default_nettype none
module kmac_top_bench import kmac_pkg::*;;
  localparam int unsigned IDL = 50;
  localparam int unsigned FRS = 20;
  localparam int unsigned BAN = 10;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ch1, ch2, pin_o, oe_n, er;
  logic [2:0] bl;
  logic signed [15:0] dval;
  kmac_keys_s want = '0, keys;
  kmac_temps_s temps = '{16'sh01f4, 16'sh00fa, 16'sh00fa};
  kmac_disp_e mode;
  kmac_func_e func;
  kmac_cfg_s cfg;
  int mismatches = 0, checks_done = 0;
  kmac_top #(.IDLE_CYCLES(IDL), .FRESET_CYCLES(FRS), .BANNER_CYCLES(BAN))
    i_kmac_top (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys(keys),
    .temps(temps), .disp_mode(mode), .disp_func(func), .disp_value(dval),
    .cfg(cfg), .backlight(bl), .ch1_alarm(ch1), .ch2_alarm(ch2),
    .open_collector_alarm_pin_o(pin_o),
    .open_collector_alarm_pin_oe_n(oe_n));
  kmac_keys_model i_kmac_keys_model (.clk_sys(clk_sys), .nrst(nrst),
    .want(want), .keys(keys));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_cfg(input kmac_cfg_s g);
    checks_done++;
    if (g !== CFG_DEFAULT) begin
      mismatches++;
      $display("CHECK FAILED %0t settings not default", $time);
    end
  endtask : chk_cfg
  // One APB transfer; the request stands until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers is a failure, not a silent read of junk
    if (pready !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t no pready on bus", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // A press is held and released long enough for the synchronous keys
  task automatic press(input kmac_keys_s k);
    @(posedge clk_sys);
    want <= k;
    cyc(3);
    want <= '0;
    cyc(3);
  endtask : press
  task automatic settemp(input logic signed [15:0] v);
    @(posedge clk_sys);
    temps.object_temperature <= v;
    cyc(5);
  endtask : settemp
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic t_reset();
    chk(32'(mode), 32'(DM_INIT));
    chk(32'(bl), 32'(BL_GREEN));
    chk_cfg(cfg);
    apb(1'b0, REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h018);
    cyc(BAN + 2);
    chk(32'(mode), 32'(DM_TEMP));
    chk(32'(dval), 32'h1f4);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    apb(1'b1, REG_CTRL, 32'hffff_fc1b, rd, er);
    apb(1'b0, REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h01b);
    apb(1'b1, REG_OUTCFG, 32'h7, rd, er);
    apb(1'b0, REG_OUTCFG, 32'h0, rd, er);
    chk(rd, 32'h12);
    apb(1'b0, REG_AVG, 32'h0, rd, er);
    chk(rd, 32'h2);
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    $display("test registers done");
  endtask : t_regs
  task automatic t_menu();
    press(3'h4);
    chk(32'({mode, func}), 32'({DM_MENU, F_OUT}));
    press(3'h2);
    chk(32'(cfg.out_type), 32'(VOLT_OUT_10));
    press(3'h4);
    press(3'h4);
    press(3'h2);
    chk(32'(cfg.peak_time), 32'h1);
    press(3'h4);
    press(3'h2);
    chk(32'({cfg.peak_time, cfg.valley_time}), 32'h1);
    cyc(IDL + 8);
    chk(32'(mode), 32'(DM_TEMP));
    press(3'h4);
    chk(32'(func), 32'(F_VALLEY));
    repeat (8) press(3'h4);
    chk(32'(func), 32'(F_AMB));
    press(3'h2);
    chk(32'(cfg.amb_fixed), 32'h1);
    want <= 3'h2;
    cyc(3);
    want <= 3'h3;
    cyc(3);
    want <= '0;
    cyc(3);
    chk(32'(cfg.amb_fixed), 32'h0);
    press(3'h4);
    press(3'h2);
    chk(32'({cfg.out_type, cfg.range_en}), 32'h8);
    $display("test menu done");
  endtask : t_menu
  // Values in tenths of a degree around 30.0 and 100.0 thresholds
  task automatic t_alarm();
    settemp(16'sh044c);
    chk(32'({bl, ch1, ch2, oe_n}), 32'h26);
    chk(32'(pin_o), 32'h0);
    settemp(16'sh03de);
    chk(32'({bl, ch1, ch2, oe_n}), 32'h26);
    settemp(16'sh03ca);
    chk(32'({bl, ch1, ch2, oe_n}), 32'h15);
    settemp(16'sh0127);
    chk(32'({bl, ch1, ch2, oe_n}), 32'h09);
    settemp(16'sh0136);
    chk(32'({bl, ch1, ch2, oe_n}), 32'h09);
    settemp(16'sh014a);
    chk(32'({bl, ch1, ch2, oe_n}), 32'h15);
    $display("test alarms done");
  endtask : t_alarm
  task automatic t_freset();
    cyc(IDL);
    want <= 3'h1;
    cyc(3);
    want <= 3'h5;
    cyc(FRS + 4);
    chk(32'(mode), 32'(DM_RESET));
    chk_cfg(cfg);
    want <= '0;
    cyc(BAN + 4);
    chk(32'(mode), 32'(DM_TEMP));
    // Pointer survives the reload; step on to unit and low alarm edits
    repeat (9) press(3'h4);
    chk(32'(func), 32'(F_UNIT));
    press(3'h2);
    chk(32'(cfg.fahrenheit), 32'h1);
    press(3'h4);
    press(3'h1);
    chk(32'(cfg.alarm_lo), 32'h12b);
    chk(32'(dval), 32'h12b);
    $display("test factory reset done");
  endtask : t_freset
  // Clock at 50 ns period
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // Watchdog: tests need well under 2000 cycles, limit is 20000
  initial begin
    #1_000_000;
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    cyc(3);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_menu();
    t_alarm();
    t_freset();
    give_verdict();
  end
endmodule : kmac_top_bench
`default_nettype wire
